// ==== irl_pkg.sv ====
package irl_pkg;

    // register indices; byte address is four times the index
    localparam logic [4:0] IRL_IDX_CTRL  = 5'h03;
    localparam logic [4:0] IRL_IDX_STAT  = 5'h04;
    localparam logic [4:0] IRL_IDX_PRIO0 = 5'h10;
    localparam logic [4:0] IRL_IDX_PRIO7 = 5'h17;

    // control field positions
    localparam int IRL_CTL_PORT = 6;
    localparam int IRL_CTL_PPS  = 5;
    localparam int IRL_CTL_FC   = 4;
    localparam int IRL_CTL_CLSH = 3;
    localparam int IRL_CTL_CLSL = 2;
    localparam int IRL_CTL_IFG  = 1;
    localparam int IRL_CTL_PRE  = 0;

    localparam logic [6:0] IRL_CTRL_RST = 7'h00;
    localparam logic [6:0] IRL_PRIO_RST = 7'h00;

    // frame classes
    localparam logic [1:0] IRL_CLS_ALL   = 2'h0;
    localparam logic [1:0] IRL_CLS_FLOOD = 2'h1;
    localparam logic [1:0] IRL_CLS_MCAST = 2'h2;

    // per-frame overhead bytes and cost units
    localparam logic [16:0] IRL_IFG_BYTES = 17'h0000c;
    localparam logic [16:0] IRL_PRE_BYTES = 17'h00008;
    localparam int          IRL_CRED_W    = 27;
    localparam logic [IRL_CRED_W-1:0] IRL_PKT_COST = 27'h00003e8;
    localparam logic [IRL_CRED_W-1:0] IRL_MAX_COST = 27'h0020000;

    // refill tick: credit is added once per millisecond
    localparam int IRL_TICK_US = 1000;
    localparam int IRL_CLK_MHZ = 250;
    localparam int IRL_TICK_CYC = IRL_TICK_US * IRL_CLK_MHZ;

    // rates: kbit/s in bit mode, packets/s in packet mode
    localparam int RATE_W = 22;
    localparam logic [RATE_W-1:0] IRL_PPS_10M  = 22'h004b00;
    localparam logic [RATE_W-1:0] IRL_PPS_100M = 22'h02ee00;
    localparam logic [RATE_W-1:0] IRL_PPS_1G   = 22'h1d4c00;
    localparam logic [RATE_W-1:0] IRL_BPS_10M  = 22'h002710;
    localparam logic [RATE_W-1:0] IRL_BPS_100M = 22'h0186a0;
    localparam logic [RATE_W-1:0] IRL_BPS_1G   = 22'h0f4240;
    localparam logic [RATE_W-1:0] IRL_PPS_STEP = 22'h000780;
    localparam logic [RATE_W-1:0] IRL_BPS_STEP = 22'h0003e8;
    localparam logic [RATE_W-1:0] IRL_LOW_PPS  = 22'h000040;
    localparam logic [RATE_W-1:0] IRL_LOW_STEP = 22'h000080;
    localparam logic [RATE_W-1:0] IRL_LOW_BPS  = 22'h000040;
    localparam logic [RATE_W-1:0] IRL_LOW_FAST = 22'h000280;
    localparam logic [RATE_W-1:0] IRL_TEN      = 22'h00000a;
    localparam logic [6:0] IRL_CODE_STEP_MAX = 7'h0a;
    localparam logic [6:0] IRL_CODE_MID_MAX  = 7'h64;
    localparam logic [6:0] IRL_CODE_LOW_MAX  = 7'h73;
    localparam logic [RATE_W-1:0] IRL_LOW_FAST_N = 22'h000003;

    typedef enum logic [1:0] {
        IRL_SPD_10   = 2'b00,
        IRL_SPD_100  = 2'b01,
        IRL_SPD_1000 = 2'b10
    } irl_speed_t;

    typedef struct packed {
        logic [13:0] len;
        logic [2:0]  prio;
        logic        bcast;
        logic        mcast;
        logic        flood;
    } irl_frame_t;

endpackage

// ==== irl_rate_lut.sv ====
module irl_rate_lut import irl_pkg::*; (
    // code and link state
    input  wire logic [6:0]        code_i,
    input  wire irl_speed_t        speed_i,
    input  wire logic              pps_i,
    // credit per tick
    output logic      [RATE_W-1:0] rate_o
);
    logic [RATE_W-1:0] c;
    logic [RATE_W-1:0] n;
    logic [RATE_W-1:0] line;
    logic [RATE_W-1:0] low;
    logic              gig;

    always_comb begin
        c = RATE_W'(code_i);
        n = c - RATE_W'(IRL_CODE_MID_MAX);
        gig = (speed_i != IRL_SPD_10) && (speed_i != IRL_SPD_100);
        case (speed_i)
            IRL_SPD_10:  line = pps_i ? IRL_PPS_10M : IRL_BPS_10M;
            IRL_SPD_100: line = pps_i ? IRL_PPS_100M : IRL_BPS_100M;
            default:     line = pps_i ? IRL_PPS_1G : IRL_BPS_1G;
        endcase
        low = (n == RATE_W'(1)) ? IRL_LOW_PPS : IRL_LOW_STEP * (n - RATE_W'(1));
        rate_o = line;
        if (code_i == 7'h00 || code_i > IRL_CODE_LOW_MAX) begin
            rate_o = line;
        end else if (code_i <= IRL_CODE_STEP_MAX) begin
            if (pps_i) begin
                rate_o = gig ? IRL_PPS_STEP * IRL_TEN * c : IRL_PPS_STEP * c;
            end else begin
                rate_o = IRL_BPS_STEP * c;
            end
        end else if (code_i <= IRL_CODE_MID_MAX) begin
            // packet mode at 10 Mb/s is undefined there; line rate is used
            if (speed_i == IRL_SPD_10) begin
                rate_o = pps_i ? line : IRL_BPS_10M;
            end else if (pps_i) begin
                rate_o = gig ? IRL_PPS_STEP * IRL_TEN * c : IRL_PPS_STEP * c;
            end else begin
                rate_o = gig ? IRL_BPS_STEP * IRL_TEN * c : IRL_BPS_STEP * c;
            end
        end else if (pps_i) begin
            rate_o = gig ? low * IRL_TEN : low;
        end else if (speed_i == IRL_SPD_10) begin
            rate_o = IRL_LOW_BPS * n;
        end else if (gig || n <= IRL_LOW_FAST_N) begin
            rate_o = IRL_LOW_FAST * n;
        end else begin
            rate_o = IRL_LOW_BPS * n;
        end
    end
endmodule

// ==== irl_bucket.sv ====
module irl_bucket import irl_pkg::*; (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // refill
    input  wire logic                  tick_i,
    input  wire logic [RATE_W-1:0]     add_i,
    // debit
    input  wire logic                  take_i,
    input  wire logic                  force_i,
    input  wire logic [IRL_CRED_W-1:0] cost_i,
    // verdict
    output logic                       ok_o
);
    // tracks credit used, so reset means a full bucket
    typedef struct packed {
        logic [IRL_CRED_W-1:0] used;
    } irl_bkt_t;

    irl_bkt_t              r;
    irl_bkt_t              next_r;
    logic [IRL_CRED_W-1:0] cap;
    logic [IRL_CRED_W:0]   sum;

    always_comb begin
        cap = IRL_CRED_W'({add_i, 4'h0}) + IRL_MAX_COST;
        sum = {1'b0, r.used} + {1'b0, cost_i};
        ok_o = sum <= {1'b0, cap};
        next_r = r;
        if (next_r.used > cap) begin
            next_r.used = cap;
        end
        if (tick_i) begin
            next_r.used = (next_r.used > IRL_CRED_W'(add_i)) ? next_r.used - IRL_CRED_W'(add_i) : '0;
        end
        if (take_i) begin
            // an over-limit frame let through under flow control drains the bucket
            next_r.used = ok_o ? sum[IRL_CRED_W-1:0] : (force_i ? cap : next_r.used);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule

// ==== irl_limiter.sv ====
module irl_limiter import irl_pkg::*; #(
    parameter int TICK_CYCLES = IRL_TICK_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // link state
    input  wire irl_speed_t  speed_i,
    input  wire logic        fc_enable_i,
    // frames from the receive mac
    input  wire logic        frm_valid_i,
    input  wire irl_frame_t  frm_i,
    output logic             frm_done_o,
    output logic             frm_drop_o,
    // flow control request
    output logic             fc_o
);
    localparam int TW = $clog2(TICK_CYCLES + 1);

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    typedef struct packed {
        logic [6:0]      ctrl;
        logic [7:0][6:0] pend;
        logic [7:0][6:0] act;
        logic            ack;
        logic [31:0]     rdat;
        logic [TW-1:0]   tcnt;
        logic            tick;
        logic            done;
        logic            drop;
        logic            fc;
    } irl_state_t;

    irl_state_t            r;
    irl_state_t            next_r;

    logic                  req;
    logic                  wr;
    logic [4:0]            idx;
    logic                  mapped;
    logic                  prio_hit;
    logic                  port_mode;
    logic                  pps;
    logic                  fc_allow;
    logic [1:0]            cls;
    logic                  counted;
    logic [2:0]            sel_idx;
    logic [16:0]           bytes;
    logic [IRL_CRED_W-1:0] cost;
    logic [7:0]            ok_v;
    logic                  ok;
    logic                  take;
    logic                  exceed;

    // bus decode; bits above the register window are unmapped
    always_comb begin
        req = wb_cyc_i && wb_stb_i && !r.ack;
        idx = wb_adr_i[6:2];
        mapped = !wb_adr_i[7];
        wr = req && wb_we_i && wb_sel_i[0] && mapped;
        prio_hit = idx[4:3] == IRL_IDX_PRIO0[4:3];
    end

    // frame classification and cost
    always_comb begin
        port_mode = r.ctrl[IRL_CTL_PORT];
        pps = r.ctrl[IRL_CTL_PPS];
        fc_allow = r.ctrl[IRL_CTL_FC] && fc_enable_i;
        cls = r.ctrl[IRL_CTL_CLSH:IRL_CTL_CLSL];
        case (cls)
            IRL_CLS_ALL:   counted = 1'b1;
            IRL_CLS_FLOOD: counted = frm_i.bcast || frm_i.mcast || frm_i.flood;
            IRL_CLS_MCAST: counted = frm_i.bcast || frm_i.mcast;
            default:       counted = frm_i.bcast;
        endcase
        sel_idx = port_mode ? 3'h0 : frm_i.prio;
        bytes = {3'h0, frm_i.len};
        if (r.ctrl[IRL_CTL_IFG]) begin
            bytes = bytes + IRL_IFG_BYTES;
        end
        if (r.ctrl[IRL_CTL_PRE] && !pps) begin
            bytes = bytes + IRL_PRE_BYTES;
        end
        // bit mode: kbit/s per ms equals bits; packet mode: one packet costs 1000 units
        cost = pps ? IRL_PKT_COST : IRL_CRED_W'({bytes, 3'h0});
        ok = ok_v[sel_idx];
        take = frm_valid_i && counted;
        exceed = take && !ok;
    end

    // one bucket per priority; port mode uses only the first
    for (genvar i = 0; i < 8; i++) begin : g_prio
        logic [RATE_W-1:0] rate;

        irl_rate_lut u_lut (
            .code_i  (r.act[i]),
            .speed_i (speed_i),
            .pps_i   (pps),
            .rate_o  (rate)
        );

        irl_bucket u_bkt (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .tick_i  (r.tick),
            .add_i   (rate),
            .take_i  (take && (sel_idx == 3'(i))),
            .force_i (fc_allow),
            .cost_i  (cost),
            .ok_o    (ok_v[i])
        );
    end

    always_comb begin
        next_r = r;
        next_r.ack = req;
        // refill tick
        next_r.tick = 1'b0;
        if (r.tcnt == TW'(TICK_CYCLES - 1)) begin
            next_r.tcnt = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.tcnt = r.tcnt + TW'(1);
        end
        // register writes
        if (wr && idx == IRL_IDX_CTRL) begin
            next_r.ctrl = wb_dat_i[6:0];
        end
        if (wr && prio_hit) begin
            next_r.pend[idx[2:0]] = wb_dat_i[6:0];
            if (idx == IRL_IDX_PRIO7) begin
                next_r.act = next_r.pend;
            end
        end
        // read data; unmapped reads return zero
        next_r.rdat = r.rdat;
        if (req) begin
            next_r.rdat = '0;
            if (mapped && idx == IRL_IDX_CTRL) begin
                next_r.rdat[6:0] = r.ctrl;
            end else if (mapped && idx == IRL_IDX_STAT) begin
                next_r.rdat[1:0] = {r.drop, r.fc};
            end else if (mapped && prio_hit) begin
                next_r.rdat[6:0] = r.pend[idx[2:0]];
            end
        end
        // verdict one cycle after the frame
        next_r.done = frm_valid_i;
        next_r.drop = exceed && !fc_allow;
        // flow control holds until the next refill, and drops at once when disabled
        next_r.fc = fc_allow && (exceed || (r.fc && !r.tick));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r.ctrl <= IRL_CTRL_RST;
            r.pend <= {8{IRL_PRIO_RST}};
            r.act <= {8{IRL_PRIO_RST}};
            r.ack <= 1'b0;
            r.rdat <= '0;
            r.tcnt <= '0;
            r.tick <= 1'b0;
            r.done <= 1'b0;
            r.drop <= 1'b0;
            r.fc <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.rdat;
    assign frm_done_o = r.done;
    assign frm_drop_o = r.drop;
    assign fc_o = r.fc;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_port_sel;
        frm_valid_i && r.ctrl[IRL_CTL_PORT] |-> sel_idx == 3'h0;
    endproperty
    a_port_sel: assert property (p_port_sel) else $error("port mode did not use bucket 0");

    property p_pps_cost;
        r.ctrl[IRL_CTL_PPS] |-> cost == IRL_PKT_COST;
    endproperty
    a_pps_cost: assert property (p_pps_cost) else $error("packet mode cost wrong");

    property p_fc_raise;
        frm_valid_i && counted && !ok && fc_allow |=> fc_o && !frm_drop_o;
    endproperty
    a_fc_raise: assert property (p_fc_raise) else $error("flow control not raised");

    property p_fc_gate;
        !(r.ctrl[IRL_CTL_FC] && fc_enable_i) |=> !fc_o;
    endproperty
    a_fc_gate: assert property (p_fc_gate) else $error("flow control without enable");

    property p_uncounted;
        frm_valid_i && !counted |=> frm_done_o && !frm_drop_o;
    endproperty
    a_uncounted: assert property (p_uncounted) else $error("uncounted frame dropped");

    property p_bit7_zero;
        wb_ack_o && prio_hit && !wb_adr_i[7] |-> wb_dat_o[31:7] == 25'h0;
    endproperty
    a_bit7_zero: assert property (p_bit7_zero) else $error("priority register upper bits set");

    property p_hold_act;
        !(wr && idx == IRL_IDX_PRIO7) |=> r.act == $past(r.act);
    endproperty
    a_hold_act: assert property (p_hold_act) else $error("limit changed without commit");

    property p_commit;
        wr && idx == IRL_IDX_PRIO7 |=> r.act[6:0] == $past(r.pend[6:0]) && r.act[7] == $past(wb_dat_i[6:0]);
    endproperty
    a_commit: assert property (p_commit) else $error("commit did not copy pending codes");

    property p_drop;
        frm_valid_i && counted && !ok && !fc_allow |=> frm_done_o && frm_drop_o;
    endproperty
    a_drop: assert property (p_drop) else $error("over-limit frame not dropped");

    property p_ack_once;
        req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("bus ack not a single cycle");
endmodule

// ==== irl_mac_model.sv ====
module irl_mac_model import irl_pkg::*; (
    // clock
    input  wire logic       clk_i,
    // frames toward the limiter
    output logic            frm_valid_o,
    output irl_frame_t      frm_o,
    // verdicts and flow control back
    input  wire logic       frm_done_i,
    input  wire logic       frm_drop_i,
    input  wire logic       fc_i
);
    timeunit 1ns;
    timeprecision 1ps;

    logic drop_q[$];
    logic fc_q[$];

    initial begin
        frm_valid_o = 1'b0;
        frm_o       = '0;
    end

    // verdict and flow request are taken together, in the cycle they stand
    always @(posedge clk_i) begin
        if (frm_done_i === 1'b1) begin
            drop_q.push_back(frm_drop_i);
            fc_q.push_back(fc_i);
        end
    end

    // one descriptor per cycle; the idle bus shows the inverse so a stale value never passes for a frame
    task automatic burst(input int n, input irl_frame_t f);
        drop_q.delete();
        fc_q.delete();
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            frm_valid_o <= 1'b1;
            frm_o       <= f;
        end
        @(posedge clk_i);
        frm_valid_o <= 1'b0;
        frm_o       <= irl_frame_t'(~f);
        repeat (3) @(posedge clk_i);
    endtask
endmodule

// ==== irl_limiter_tb.sv ====
module irl_limiter_tb import irl_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int         TICK  = 2;
    localparam int         LIMIT = 80000;
    localparam logic [5:0] P0    = {1'b0, IRL_IDX_PRIO0};
    localparam logic [5:0] P7    = {1'b0, IRL_IDX_PRIO7};
    localparam logic [5:0] CT    = {1'b0, IRL_IDX_CTRL};

    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    irl_speed_t  speed_i;
    logic        fc_enable_i;
    logic        frm_valid_i;
    irl_frame_t  frm_i;
    logic        frm_done_o;
    logic        frm_drop_o;
    logic        fc_o;
    int          fail_count;
    int          checks_done;
    int          cyc_count;

    irl_limiter #(
        .TICK_CYCLES (TICK)
    ) dut_u (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .wb_cyc_i    (wb_cyc_i),
        .wb_stb_i    (wb_stb_i),
        .wb_we_i     (wb_we_i),
        .wb_adr_i    (wb_adr_i),
        .wb_sel_i    (wb_sel_i),
        .wb_dat_i    (wb_dat_i),
        .wb_dat_o    (wb_dat_o),
        .wb_ack_o    (wb_ack_o),
        .speed_i     (speed_i),
        .fc_enable_i (fc_enable_i),
        .frm_valid_i (frm_valid_i),
        .frm_i       (frm_i),
        .frm_done_o  (frm_done_o),
        .frm_drop_o  (frm_drop_o),
        .fc_o        (fc_o)
    );

    irl_mac_model mac_u (
        .clk_i       (clk_i),
        .frm_valid_o (frm_valid_i),
        .frm_o       (frm_i),
        .frm_done_i  (frm_done_o),
        .frm_drop_i  (frm_drop_o),
        .fc_i        (fc_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc_count++;
        if (cyc_count == LIMIT) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chkq(input int i, input logic e);
        chk("frame drop", {31'h0, mac_u.drop_q[i]}, {31'h0, e});
    endtask

    // a verdict that never arrived counts as a drop, so a silent port cannot pass a no-drop check
    function automatic int ndrop(input int lo, input int hi);
        int n;
        n = 0;
        for (int i = lo; i <= hi; i++) begin
            if (mac_u.drop_q[i] !== 1'b0) n++;
        end
        return n;
    endfunction

    function automatic irl_frame_t fr(input int len, input logic [2:0] kind, input logic [2:0] pr);
        irl_frame_t f;
        f.len = len[13:0];
        f.prio = pr;
        {f.bcast, f.mcast, f.flood} = kind;
        return f;
    endfunction

    task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] d, input logic [3:0] sel,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= d;
        // no local limit: a slave that never answers runs into the cycle ceiling
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        // the slave answers one cycle after it takes the request
        chk("bus ack latency", n, 32'd2);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, 4'hf, q);
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, idx, 32'h0, 4'hf, q);
        chk("register read", q, e);
    endtask

    // at code 101 the drain leaves the priority 0 bucket near empty whatever the old code left in it
    task automatic prep(input logic [6:0] ctl, input logic [6:0] code, input irl_speed_t spd, input bit fill);
        @(posedge clk_i);
        rst_i   <= 1'b1;
        speed_i <= spd;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(CT, {25'h0, ctl});
        wr(P0, {25'h0, code});
        wr(P7, 32'h0);
        mac_u.burst(300, fr(16383, 3'b000, 3'd0));
        mac_u.burst(300, fr(64, 3'b000, 3'd0));
        if (fill) repeat (4400) @(posedge clk_i);
    endtask

    task automatic t_regs();
        logic [31:0] q;
        for (int i = 0; i < 8; i++) rd_chk(P0 + 6'(i), 32'h0);
        for (int i = 0; i < 8; i++) wr(P0 + 6'(i), 32'hb1 + 32'(i));
        for (int i = 0; i < 8; i++) rd_chk(P0 + 6'(i), 32'h31 + 32'(i));
        wb(1'b1, P0, 32'h11, 4'h0, q);
        rd_chk(P0, 32'h31);
        wr(6'h20, 32'h55);
        rd_chk(6'h20, 32'h0);
        wr(CT, 32'hff);
        rd_chk(CT, 32'h7f);
        $display("test registers finished");
    endtask

    task automatic t_commit();
        prep(7'h00, 7'd0, IRL_SPD_1000, 1'b0);
        wr(P0, 32'd101);
        mac_u.burst(20, fr(16383, 3'b000, 3'd0));
        chk("drops before commit", ndrop(0, 19), 0);
        wr(P7, 32'h0);
        mac_u.burst(200, fr(16383, 3'b000, 3'd0));
        chk("drops after commit", {31'h0, ndrop(0, 199) > 0}, 1);
        $display("test commit finished");
    endtask

    task automatic t_bytes();
        logic [6:0] cfg [3] = '{7'h00, 7'h02, 7'h01};
        int         idx [3] = '{15, 14, 14};
        for (int k = 0; k < 3; k++) begin
            prep(cfg[k], 7'd101, IRL_SPD_10, 1'b1);
            mac_u.burst(16, fr(1100, 3'b000, 3'd0));
            chk("frames passed", ndrop(0, idx[k] - 1), 0);
            chkq(idx[k], 1'b1);
        end
        $display("test byte count finished");
    endtask

    task automatic t_pps();
        prep(7'h23, 7'd101, IRL_SPD_10, 1'b1);
        mac_u.burst(140, fr(16383, 3'b000, 3'd0));
        chk("packets passed", ndrop(0, 129), 0);
        chkq(139, 1'b1);
        $display("test packet mode finished");
    endtask

    task automatic t_mid();
        irl_speed_t sp [2] = '{IRL_SPD_10, IRL_SPD_100};
        for (int k = 0; k < 2; k++) begin
            prep(7'h00, 7'd50, sp[k], 1'b1);
            mac_u.burst(3, fr(16000, 3'b000, 3'd0));
            chkq(2, k == 0);
        end
        $display("test mid codes finished");
    endtask

    task automatic t_mode();
        prep(7'h00, 7'd101, IRL_SPD_10, 1'b0);
        mac_u.burst(1, fr(16383, 3'b000, 3'd3));
        chkq(0, 1'b0);
        wr(CT, 32'h40);
        mac_u.burst(1, fr(16383, 3'b000, 3'd3));
        chkq(0, 1'b1);
        $display("test port mode finished");
    endtask

    task automatic t_class();
        logic [2:0] kind [4] = '{3'b000, 3'b001, 3'b010, 3'b100};
        logic [3:0] cnt  [4] = '{4'b1111, 4'b1110, 4'b1100, 4'b1000};
        prep(7'h00, 7'd101, IRL_SPD_10, 1'b0);
        for (int c = 0; c < 4; c++) begin
            wr(CT, {28'h0, 2'(c), 2'b00});
            for (int k = 0; k < 4; k++) begin
                mac_u.burst(1, fr(16383, kind[k], 3'd0));
                chkq(0, cnt[c][k]);
            end
        end
        $display("test frame class finished");
    endtask

    task automatic t_fc();
        logic [6:0] cfg [3] = '{7'h10, 7'h10, 7'h00};
        logic       en  [3] = '{1'b1, 1'b0, 1'b1};
        logic       fcx [3] = '{1'b1, 1'b0, 1'b0};
        prep(7'h00, 7'd101, IRL_SPD_10, 1'b0);
        for (int k = 0; k < 3; k++) begin
            fc_enable_i <= en[k];
            wr(CT, {25'h0, cfg[k]});
            mac_u.burst(1, fr(16383, 3'b000, 3'd0));
            chkq(0, ~fcx[k]);
            chk("flow control", {31'h0, mac_u.fc_q[0]}, {31'h0, fcx[k]});
        end
        $display("test flow control finished");
    endtask

    initial begin
        fail_count  = 0;
        checks_done = 0;
        cyc_count   = 0;
        rst_i       = 1'b1;
        wb_cyc_i    = 1'b0;
        wb_stb_i    = 1'b0;
        wb_we_i     = 1'b0;
        wb_adr_i    = 8'h00;
        wb_sel_i    = 4'h0;
        wb_dat_i    = 32'h0;
        speed_i     = IRL_SPD_10;
        fc_enable_i = 1'b0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_commit();
        t_bytes();
        t_pps();
        t_mid();
        t_mode();
        t_class();
        t_fc();
        stop_test();
    end
endmodule
